// File: btsd_pkg.sv
// Package for the bit-test-and-skip decoder: opcodes, field layout,
// address mapping constants and carrier structs.
// Assumes a single core clock domain; no register bus.
package btsd_pkg;

  // Opcode in the top nibble of the instruction word
  localparam logic [3:0] OPC_SKIP_IF_CLEAR = 4'hb;
  localparam logic [3:0] OPC_SKIP_IF_SET = 4'ha;

  // Field positions of the 16-bit instruction word
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 12;
  localparam int BIT_MSB = 11;
  localparam int BIT_LSB = 9;
  localparam int ACC_POS = 8;
  localparam int REG_MSB = 7;
  localparam int REG_LSB = 0;

  // Access bank split and literal-offset limit
  localparam logic [7:0] LIT_OFS_MAX = 8'h5f;
  localparam logic [7:0] ACC_BANK_SPLIT = 8'h60;
  localparam logic [3:0] ACC_HIGH_BANK = 4'hf;
  localparam logic [3:0] ACC_LOW_BANK = 4'h0;

  // No-operation word placed in the flushed slot
  localparam logic [15:0] NO_OPERATION_WORD = 16'h0000;

  // Reset values
  localparam logic [11:0] ADDR_RST = 12'h000;
  localparam logic [15:0] INSN_RST = 16'h0000;

  // Decoded fields of one instruction
  typedef struct packed {
    logic is_clear;
    logic is_set;
    logic [2:0] bit_idx;
    logic access;
    logic [7:0] reg_addr;
  } btsd_dec_t;

  // Data memory request toward the register file
  typedef struct packed {
    logic valid;
    logic indexed;
    logic [11:0] addr;
  } btsd_mem_req_t;

endpackage

// File: btsd_field_dec.sv
// Pure field decoder for the bit-test instruction word.
// Assumes the word is stable while insn_valid is high.
`timescale 1ns/1ps
module btsd_field_dec (
  input wire logic [15:0] insn,
  input wire logic insn_valid,
  output btsd_pkg::btsd_dec_t dec
);

  // Split word into opcode, bit index, access bit, address
  always_comb begin
    dec.is_clear = insn_valid &&
      (insn[btsd_pkg::OPC_MSB:btsd_pkg::OPC_LSB] ==
       btsd_pkg::OPC_SKIP_IF_CLEAR); // [RULE1] [RULE6]
    dec.is_set = insn_valid &&
      (insn[btsd_pkg::OPC_MSB:btsd_pkg::OPC_LSB] ==
       btsd_pkg::OPC_SKIP_IF_SET); // [RULE2] [RULE6]
    dec.bit_idx = insn[btsd_pkg::BIT_MSB:btsd_pkg::BIT_LSB]; // [RULE6]
    dec.access = insn[btsd_pkg::ACC_POS]; // [RULE6]
    dec.reg_addr = insn[btsd_pkg::REG_MSB:btsd_pkg::REG_LSB]; // [RULE6]
  end

endmodule // btsd_field_dec

// File: btsd_decoder.sv
// Decode and execute logic for the two bit-test-and-skip instructions.
// Assumes the core presents one instruction word per enabled cycle and
// returns the addressed data byte in the same cycle as the memory request.
// Tests that arrive while one is in flight are ignored, not queued, so
// the core must space them two enabled cycles apart, three after a skip.
//
// Notes on behaviour
// [RULE1] Top nibble 1011 is skip-if-clear; skip when tested bit is 0.
// [RULE2] Top nibble 1010 is skip-if-set; skip when tested bit is 1.
// [RULE3] On skip, flush the prefetched word, run a no-operation cycle.
// [RULE4] Access bit 0 targets access bank; 1 uses bank select pointer.
// [RULE5] Access 0 with extended set and address <= 5Fh uses indexed mode.
// [RULE6] Word is opcode, bit index, access bit, address; no flags change.
`timescale 1ns/1ps
module btsd_decoder #(
  parameter int BANK_W = 4
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [15:0] insn,
  input wire logic insn_valid,
  input wire logic [BANK_W-1:0] bank_select_pointer,
  input wire logic ext_insn_en,
  input wire logic [11:0] index_base,
  input wire logic [7:0] mem_rdata,
  output btsd_pkg::btsd_mem_req_t mem_req,
  output logic test_busy,
  output logic skip_taken,
  output logic flush_prefetch,
  output logic no_operation,
  output logic [15:0] exec_insn
);

  typedef enum logic [1:0] {
    BTSD_IDLE,
    BTSD_TEST,
    BTSD_NOP
  } btsd_state_t;

  btsd_state_t state_q;
  btsd_pkg::btsd_dec_t dec;
  logic is_clear_q;
  logic [2:0] bit_idx_q;
  logic [11:0] addr_d;
  logic indexed_d;
  logic skip_d;
  logic take_d;
  logic skip_now;

  btsd_field_dec u_dec (
    .insn(insn),
    .insn_valid(insn_valid),
    .dec(dec)
  );

  // True for either bit-test opcode in the decoded word
  function automatic logic btsd_is_test(
    input btsd_pkg::btsd_dec_t d
  );
    return d.is_clear || d.is_set; // [RULE1] [RULE2]
  endfunction

  // Literal-offset window: access bank, extended set, low address
  function automatic logic btsd_is_lit_ofs(
    input logic access,
    input logic ext_en,
    input logic [7:0] f
  );
    return !access && ext_en && (f <= btsd_pkg::LIT_OFS_MAX); // [RULE5]
  endfunction

  // Tested bit against the polarity of the opcode
  function automatic logic btsd_skip_due(
    input logic clear_op,
    input logic [7:0] data,
    input logic [2:0] idx
  );
    logic b;
    b = data[idx];
    return clear_op ? !b : b; // [RULE1] [RULE2]
  endfunction

  // Bank choice for an 8-bit operand address
  function automatic logic [11:0] btsd_map_addr(
    input logic access,
    input logic ext_en,
    input logic [7:0] f,
    input logic [BANK_W-1:0] bank,
    input logic [11:0] base
  );
    logic [11:0] r;
    logic [12:0] sum;
    r = {bank[3:0], f}; // Banked access by default
    sum = {1'b0, base} + {5'h00, f};
    if (btsd_is_lit_ofs(access, ext_en, f)) begin
      // Carry out of the 4K data space is dropped on purpose
      r = sum[11:0]; // Literal offset from index base
    end else if (!access && (f < btsd_pkg::ACC_BANK_SPLIT)) begin
      r = {btsd_pkg::ACC_LOW_BANK, f};
    end else if (!access) begin
      r = {btsd_pkg::ACC_HIGH_BANK, f};
    end
    return r;
  endfunction

  // Operand address for the incoming test
  always_comb begin
    addr_d = btsd_map_addr(dec.access, ext_insn_en, dec.reg_addr,
      bank_select_pointer, index_base); // [RULE4] [RULE5]
    indexed_d = btsd_is_lit_ofs(dec.access, ext_insn_en,
      dec.reg_addr); // [RULE5]
  end

  // Skip decision from returned data byte
  always_comb begin
    skip_d = btsd_skip_due(is_clear_q, mem_rdata,
      bit_idx_q); // [RULE1] [RULE2]
  end

  // Acceptance and skip strobes shared by several processes
  always_comb begin
    take_d = (state_q == BTSD_IDLE) &&
      btsd_is_test(dec); // [RULE1] [RULE2]
    skip_now = (state_q == BTSD_TEST) && skip_d; // [RULE3]
  end

  // Sequencer: idle, test, optional no-operation slot
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= BTSD_IDLE;
    end else if (clk_en) begin
      case (state_q)
        BTSD_IDLE: begin
          // Only an idle sequencer accepts; later tests are dropped
          if (take_d) begin
            state_q <= BTSD_TEST;
          end
        end
        BTSD_TEST: begin
          state_q <= skip_d ? BTSD_NOP : BTSD_IDLE; // [RULE3]
        end
        BTSD_NOP: begin
          // Flushed slot; the word on insn is not decoded here
          state_q <= BTSD_IDLE;
        end
        default: begin
          state_q <= BTSD_IDLE;
        end
      endcase
    end
  end

  // Latch test fields while the sequencer is idle
  // Loaded every idle cycle; only the accepted word's copy is used
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      is_clear_q <= 1'b0;
      bit_idx_q <= 3'h0;
    end else if (clk_en && state_q == BTSD_IDLE) begin
      is_clear_q <= dec.is_clear;
      bit_idx_q <= dec.bit_idx;
    end
  end

  // Memory read request, one cycle long
  // Address follows every enabled cycle; only valid qualifies it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mem_req <= '{valid: 1'b0, indexed: 1'b0, addr: btsd_pkg::ADDR_RST};
    end else if (clk_en) begin
      mem_req.valid <= take_d; // [RULE1] [RULE2]
      mem_req.indexed <= indexed_d;
      mem_req.addr <= addr_d; // [RULE4]
    end
  end

  // Acceptance pulse, one enabled cycle per taken test
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      test_busy <= 1'b0;
    end else if (clk_en) begin
      test_busy <= take_d; // [RULE1] [RULE2]
    end
  end

  // Skip pulse; status flags are never touched by this block
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      skip_taken <= 1'b0;
    end else if (clk_en) begin
      skip_taken <= skip_now; // [RULE1] [RULE2] [RULE6]
    end
  end

  // Fetch unit drops the word it prefetched during the test
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flush_prefetch <= 1'b0;
    end else if (clk_en) begin
      flush_prefetch <= skip_now; // [RULE3]
    end
  end

  // No-operation marker for the slot the flushed word would have used
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      no_operation <= 1'b0;
    end else if (clk_en) begin
      no_operation <= skip_now; // [RULE3]
    end
  end

  // Executed word: the prefetched one, or a no-operation in its place,
  // so a taken skip costs exactly one extra cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      exec_insn <= btsd_pkg::INSN_RST;
    end else if (clk_en) begin
      exec_insn <= skip_now ?
        btsd_pkg::NO_OPERATION_WORD : insn; // [RULE3] [RULE6]
    end
  end

endmodule // btsd_decoder

// File: btsd_asserts.sv
// Checker for btsd_decoder: issue, skip, flush and address map.
// Assumes one clock, async active-low reset, clk_en freezing state.
`timescale 1ns/1ps
module btsd_asserts #(parameter int BANK_W = 4) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [15:0] insn,
  input wire logic insn_valid,
  input wire logic [BANK_W-1:0] bank_select_pointer,
  input wire logic ext_insn_en,
  input wire logic [11:0] index_base,
  input wire logic [7:0] mem_rdata,
  input wire btsd_pkg::btsd_mem_req_t mem_req,
  input wire logic skip_taken,
  input wire logic test_busy,
  input wire logic flush_prefetch,
  input wire logic no_operation
);
  logic [15:0] w_q;
  logic [BANK_W-1:0] bank_q;
  logic [11:0] base_q;
  logic ext_q;
  // Idle core seeing a test word; a busy one ignores it
  wire take = insn_valid && insn[15:13] == 3'h5 && !mem_req.valid &&
    !skip_taken;
  wire lit = !w_q[8] && ext_q && w_q[7:0] <= 8'h5f;
  // Word and mapping inputs of the test in flight, as taken
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      w_q <= 16'h0000;
      bank_q <= {BANK_W{1'b0}};
      base_q <= 12'h000;
      ext_q <= 1'b0;
    end else if (clk_en && take) begin
      w_q <= insn;
      bank_q <= bank_select_pointer;
      base_q <= index_base;
      ext_q <= ext_insn_en;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst || !clk_en);
  a_test_issue:
    assert property (take |=> mem_req.valid && test_busy) else $error("no issue");
  a_skip_clear:
    assert property (mem_req.valid && w_q[12] |=>
      skip_taken == !$past(mem_rdata[w_q[11:9]])) else $error("clear skip");
  a_skip_set:
    assert property (mem_req.valid && !w_q[12] |=>
      skip_taken == $past(mem_rdata[w_q[11:9]])) else $error("set skip");
  a_flush_nop:
    assert property ({flush_prefetch, no_operation} == {2{skip_taken}})
      else $error("flush");
  a_skip_gap:
    assert property (skip_taken |=> !skip_taken && !mem_req.valid)
      else $error("nop slot");
  a_bank_sel:
    assert property (mem_req.valid && w_q[8] |-> !mem_req.indexed &&
      mem_req.addr == {bank_q, w_q[7:0]}) else $error("bank");
  a_access_bank:
    assert property (mem_req.valid && !w_q[8] && !lit |-> mem_req.addr ==
      {w_q[7:0] > 8'h5f ? 4'hf : 4'h0, w_q[7:0]}) else $error("access");
  a_lit_offset:
    assert property (mem_req.valid && lit |-> mem_req.indexed &&
      mem_req.addr == base_q + w_q[7:0]) else $error("indexed");
  c_skip: cover property (skip_taken);
  c_lit: cover property (mem_req.valid && lit);
  c_refused: cover property (mem_req.valid && insn_valid && insn[14]==1'b0);
endmodule // btsd_asserts

bind btsd_decoder btsd_asserts #(.BANK_W(BANK_W)) btsd_asserts_i (.mclk,
  .nrst, .clk_en, .insn, .insn_valid, .bank_select_pointer, .ext_insn_en,
  .index_base, .mem_rdata, .mem_req, .skip_taken, .test_busy,
  .flush_prefetch, .no_operation);

// File: tb.sv
// Random bench for btsd_decoder with address boundary cases.
// Drives inputs on the falling edge of a 25 MHz mclk.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t mismatch", $time); end end
module tb;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic insn_valid = 1'b0;
  logic ext_insn_en = 1'b0;
  logic [3:0] bank_select_pointer = 4'h0;
  logic [11:0] index_base = 12'h000;
  logic [7:0] mem_rdata = 8'h00;
  logic [15:0] insn = 16'h0000;
  logic [15:0] fill, exec_insn;
  btsd_pkg::btsd_mem_req_t mem_req, r;
  logic test_busy, skip_taken, flush_prefetch, no_operation, t, s;
  int n_fail = 0, checked = 0, seed = 32'h3d69;
  btsd_decoder btsd_decoder_i (.mclk, .nrst, .clk_en, .insn,
    .insn_valid, .bank_select_pointer, .ext_insn_en, .index_base,
    .mem_rdata, .mem_req, .test_busy, .skip_taken, .flush_prefetch,
    .no_operation, .exec_insn);
  // 40 ns period
  initial begin
    forever #20 mclk = ~mclk;
  end
  // Expected data request for the word now on insn
  function automatic btsd_pkg::btsd_mem_req_t exp_req();
    if (insn[8]) return {2'h2, bank_select_pointer, insn[7:0]};
    if (ext_insn_en && insn[7:0] <= 8'h5f)
      return {2'h3, index_base + 12'(insn[7:0])};
    return {2'h2, insn[7:0] > 8'h5f ? 4'hf : 4'h0, insn[7:0]};
  endfunction
  task automatic results();
    $display("Counts: %0d checked, %0d bad", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Test word, prefetched word, then a quiet cycle
  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    nrst = 1'b1;
    for (int i = 0; i < 400; i++) begin
      {insn, fill, index_base, bank_select_pointer} =
        48'({$random(seed), $random(seed)});
      {mem_rdata, ext_insn_en} = 9'($random(seed));
      if (insn[14]) insn[15:13] = 3'h5; // Mostly tests
      if (i < 8) {insn[15:13], insn[8:0]} = {4'ha, 8'h5c + 8'(i)};
      insn_valid = 1'b1;
      t = insn[15:13] == 3'h5;
      s = t && (mem_rdata[insn[11:9]] ^ insn[12]);
      r = exp_req();
      if (!t) fill[14] = 1'b1; // Keeps a test out of the idle slot
      @(negedge mclk);
      `CHK({mem_req.valid, test_busy}, {t, t})
      if (t) `CHK(mem_req, r)
      insn = fill;
      if (i % 5 == 2) begin
        clk_en = 1'b0; // Frozen edge: pulses and state must hold
        @(negedge mclk);
        `CHK({mem_req.valid, test_busy, skip_taken}, {t, t, 1'b0})
        clk_en = 1'b1;
      end
      @(negedge mclk);
      `CHK({skip_taken, flush_prefetch, no_operation}, {3{s}})
      `CHK(exec_insn, s ? btsd_pkg::NO_OPERATION_WORD : fill)
      `CHK(mem_req.valid, 1'b0)
      insn_valid = 1'b0;
      @(negedge mclk);
      `CHK({skip_taken, mem_req.valid}, 2'h0)
      if (i == 200) begin
        nrst = 1'b0; // Mid-run reset clears every registered output
        @(negedge mclk);
        `CHK({mem_req, test_busy, skip_taken, exec_insn}, '0)
        nrst = 1'b1;
      end
    end
    results();
  end
endmodule // tb
